// >>> pcatb_timebase.sv
// Shared 16-bit auto-reload time base and global control for eight modules.
// Assumes module datapaths supply hit pulses, enables and mode qualifiers.
`timescale 1ns/1ns
`default_nettype none
module pcatb_timebase (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] sfr_addr,
  input wire logic [3:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cpu_idle,
  input wire logic timer0_overflow,
  input wire logic uart0_rate_gen_overflow,
  input wire logic ext_tick_pin,
  input wire logic fast_mix_source,
  input wire logic master_divider_out,
  input wire logic toggle_pin_enable,
  output logic overflow_toggle_out,
  output logic toggle_pin_o,
  output logic toggle_pin_oe,
  input wire logic [7:0] module_hit,
  input wire logic [7:0] module_irq_enable,
  input wire logic [5:0] module_mode_ok,
  output logic [2:0] pair_buffer_active,
  output logic [15:0] count_value,
  output logic count_tick,
  input wire logic [7:0] module_pin_use,
  input wire logic [7:0] module_pin_drive,
  input wire logic [7:0] module_pin_drive_oe,
  input wire logic [7:0] gpio_out,
  input wire logic [7:0] gpio_oe,
  output logic [7:0] module_pin_o,
  output logic [7:0] module_pin_oe,
  output logic irq
);

  // ****************************************
  // Register bus decode
  // ****************************************
  function automatic logic sfr_hit(input logic [7:0] addr, input logic [3:0] page,
                                   input logic [7:0] want, input logic any_page,
                                   input logic [3:0] want_page);
    sfr_hit = (addr == want) && (any_page || (page == want_page));
  endfunction : sfr_hit

  logic sel_rl;
  logic sel_rh;
  logic sel_ctl;
  logic sel_mode;
  logic sel_cl;
  logic sel_ch;
  logic sel_aux6;
  logic sel_aux7;

  assign sel_rl = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_RELOAD_LOW, 1'b1,
                          pcatb_pkg::PAGE_MAIN);
  assign sel_rh = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_RELOAD_HIGH, 1'b1,
                          pcatb_pkg::PAGE_MAIN);
  assign sel_ctl = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_CONTROL, 1'b0,
                           pcatb_pkg::PAGE_MAIN);
  assign sel_mode = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_MODE, 1'b0,
                            pcatb_pkg::PAGE_MAIN);
  assign sel_cl = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_COUNT_LOW, 1'b1,
                          pcatb_pkg::PAGE_MAIN);
  assign sel_ch = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_COUNT_HIGH, 1'b1,
                          pcatb_pkg::PAGE_MAIN);
  assign sel_aux6 = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_PWM_AUX6, 1'b0,
                            pcatb_pkg::PAGE_AUX);
  assign sel_aux7 = sfr_hit(sfr_addr, sfr_page, pcatb_pkg::ADDR_PWM_AUX7, 1'b0,
                            pcatb_pkg::PAGE_AUX);

  logic [7:0] reload_low_q;
  logic [7:0] reload_high_q;
  logic [7:0] mode_q;
  logic counter_run_q;
  logic overflow_flag_q;
  logic [5:0] event_flag_q;
  logic [7:0] aux6_q;
  logic [7:0] aux7_q;
  logic [15:0] count_q;
  logic toggle_q;
  logic [7:0] rdata_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      reload_low_q <= pcatb_pkg::RESET_BYTE;
      reload_high_q <= pcatb_pkg::RESET_BYTE;
      mode_q <= pcatb_pkg::RESET_BYTE;
    end else if (sfr_wr) begin
      if (sel_rl) begin
        reload_low_q <= sfr_wdata;
      end
      if (sel_rh) begin
        reload_high_q <= sfr_wdata;
      end
      if (sel_mode) begin
        mode_q <= sfr_wdata;
      end
    end
  end

  // ****************************************
  // Tick source selection
  // ****************************************
  logic tick_div12;
  logic tick_div2;
  logic ext_fall;
  logic mix_rise;
  logic mdo_rise;
  logic tick_sel;

  pcatb_prescale u_prescale (
    .clk(clk),
    .reset_n(reset_n),
    .tick_div12(tick_div12),
    .tick_div2(tick_div2)
  );

  pcatb_edge_sync u_ext_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(ext_tick_pin),
    .rise(),
    .fall(ext_fall)
  );

  pcatb_edge_sync u_mix_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(fast_mix_source),
    .rise(mix_rise),
    .fall()
  );

  pcatb_edge_sync u_mdo_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in(master_divider_out),
    .rise(mdo_rise),
    .fall()
  );

  always_comb begin
    case (mode_q[pcatb_pkg::MODE_SEL_HI:pcatb_pkg::MODE_SEL_LO])
      pcatb_pkg::SRC_DIV12: tick_sel = tick_div12;
      pcatb_pkg::SRC_DIV2: tick_sel = tick_div2;
      pcatb_pkg::SRC_TIMER0: tick_sel = timer0_overflow;
      pcatb_pkg::SRC_EXT_PIN: tick_sel = ext_fall;
      pcatb_pkg::SRC_FAST_MIX: tick_sel = mix_rise;
      pcatb_pkg::SRC_DIV1: tick_sel = 1'b1;
      pcatb_pkg::SRC_UART0: tick_sel = uart0_rate_gen_overflow;
      pcatb_pkg::SRC_MASTER_DIV: tick_sel = mdo_rise;
      default: tick_sel = 1'b0;
    endcase
  end

  // ****************************************
  // Counter
  // ****************************************
  logic count_en;
  logic overflow;
  logic count_wr;

  assign count_en = tick_sel & counter_run_q & ~(mode_q[pcatb_pkg::MODE_IDLE_GATE] & cpu_idle);
  assign overflow = count_en & (count_q == pcatb_pkg::COUNT_MAX);
  assign count_wr = sfr_wr & (sel_cl | sel_ch);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_q <= pcatb_pkg::RESET_COUNT;
    end else if (count_wr) begin
      if (sel_cl) begin
        count_q[7:0] <= sfr_wdata;
      end
      if (sel_ch) begin
        count_q[15:8] <= sfr_wdata;
      end
    end else if (overflow) begin
      count_q <= {reload_high_q, reload_low_q};
    end else if (count_en) begin
      count_q <= count_q + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toggle_q <= 1'b0;
    end else if (overflow) begin
      toggle_q <= ~toggle_q;
    end
  end

  logic toggle_oe_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      toggle_oe_q <= 1'b0;
    end else begin
      toggle_oe_q <= toggle_pin_enable;
    end
  end

  assign overflow_toggle_out = toggle_q;
  assign toggle_pin_o = toggle_q;
  assign toggle_pin_oe = toggle_oe_q;
  assign count_value = count_q;
  assign count_tick = count_en;

  // ****************************************
  // Control register and flags
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      counter_run_q <= 1'b0;
    end else if (sfr_wr && sel_ctl) begin
      counter_run_q <= sfr_wdata[pcatb_pkg::CTRL_COUNTER_RUN];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      overflow_flag_q <= 1'b0;
    end else if (overflow) begin
      overflow_flag_q <= 1'b1;
    end else if (sfr_wr && sel_ctl) begin
      overflow_flag_q <= sfr_wdata[pcatb_pkg::CTRL_OVERFLOW_FLAG];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      event_flag_q <= 6'h00;
    end else if (sfr_wr && sel_ctl) begin
      event_flag_q <= sfr_wdata[5:0] | module_hit[5:0];
    end else begin
      event_flag_q <= event_flag_q | module_hit[5:0];
    end
  end

  // Module 6 and 7 aux flags.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      aux6_q <= pcatb_pkg::RESET_BYTE;
      aux7_q <= pcatb_pkg::RESET_BYTE;
    end else begin
      if (sfr_wr && sel_aux6) begin
        aux6_q <= sfr_wdata & pcatb_pkg::AUX_WRITE_MASK;
      end
      if (module_hit[6]) begin
        aux6_q[pcatb_pkg::AUX_EVENT_FLAG] <= 1'b1;
      end
      if (sfr_wr && sel_aux7) begin
        aux7_q <= sfr_wdata & pcatb_pkg::AUX_WRITE_MASK;
      end
      if (module_hit[7]) begin
        aux7_q[pcatb_pkg::AUX_EVENT_FLAG] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Interrupt request, buffer pairs, pins
  // ****************************************
  logic [7:0] all_flags;
  logic irq_q;
  logic [2:0] pair_q;
  logic [7:0] pin_o_q;
  logic [7:0] pin_oe_q;

  assign all_flags = {aux7_q[pcatb_pkg::AUX_EVENT_FLAG], aux6_q[pcatb_pkg::AUX_EVENT_FLAG],
                      event_flag_q};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= (overflow_flag_q & mode_q[pcatb_pkg::MODE_OVF_IRQ_EN]) |
               (|(all_flags & module_irq_enable));
    end
  end
  assign irq = irq_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pair_q <= 3'h0;
    end else begin
      pair_q[0] <= mode_q[pcatb_pkg::MODE_PAIR01] & module_mode_ok[0] & module_mode_ok[1];
      pair_q[1] <= mode_q[pcatb_pkg::MODE_PAIR23] & module_mode_ok[2] & module_mode_ok[3];
      pair_q[2] <= mode_q[pcatb_pkg::MODE_PAIR45] & module_mode_ok[4] & module_mode_ok[5];
    end
  end
  assign pair_buffer_active = pair_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_o_q <= 8'h00;
      pin_oe_q <= 8'h00;
    end else begin
      pin_o_q <= (module_pin_use & module_pin_drive) | (~module_pin_use & gpio_out);
      pin_oe_q <= (module_pin_use & module_pin_drive_oe) | (~module_pin_use & gpio_oe);
    end
  end
  assign module_pin_o = pin_o_q;
  assign module_pin_oe = pin_oe_q;

  // ****************************************
  // Read data
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd) begin
      if (sel_rl) begin
        rdata_q <= reload_low_q;
      end else if (sel_rh) begin
        rdata_q <= reload_high_q;
      end else if (sel_ctl) begin
        rdata_q <= {overflow_flag_q, counter_run_q, event_flag_q};
      end else if (sel_mode) begin
        rdata_q <= mode_q;
      end else if (sel_cl) begin
        rdata_q <= count_q[7:0];
      end else if (sel_ch) begin
        rdata_q <= count_q[15:8];
      end else if (sel_aux6) begin
        rdata_q <= aux6_q;
      end else if (sel_aux7) begin
        rdata_q <= aux7_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end
  assign sfr_rdata = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  property p_reload;
    @(posedge clk) disable iff (!reset_n)
    (overflow && !count_wr) |=> (count_q == $past({reload_high_q, reload_low_q}));
  endproperty
  a_reload: assert property (p_reload) else $error("counter did not reload");

  property p_ovf_flag;
    @(posedge clk) disable iff (!reset_n)
    overflow |=> overflow_flag_q ##1 (irq || !$past(mode_q[pcatb_pkg::MODE_OVF_IRQ_EN]));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow flag not set");

  property p_toggle;
    @(posedge clk) disable iff (!reset_n)
    overflow |=> (toggle_q != $past(toggle_q));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle did not flip");

  property p_pin_oe;
    @(posedge clk) disable iff (!reset_n)
    toggle_pin_oe == $past(toggle_pin_enable);
  endproperty
  a_pin_oe: assert property (p_pin_oe) else $error("toggle pin enable wrong");

  property p_stopped;
    @(posedge clk) disable iff (!reset_n)
    (!counter_run_q && !count_wr) |=> $stable(count_q);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter ran while stopped");

  property p_idle;
    @(posedge clk) disable iff (!reset_n)
    (mode_q[pcatb_pkg::MODE_IDLE_GATE] && cpu_idle && !count_wr) |=> $stable(count_q);
  endproperty
  a_idle: assert property (p_idle) else $error("counter ran in idle");

  property p_ext_edge;
    @(posedge clk) disable iff (!reset_n)
    (counter_run_q && !cpu_idle && !count_wr && count_q != pcatb_pkg::COUNT_MAX &&
     mode_q[3:1] == pcatb_pkg::SRC_EXT_PIN && ext_fall) |=> (count_q == $past(count_q) + 16'h0001);
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("external edge not counted");

  property p_event;
    @(posedge clk) disable iff (!reset_n)
    module_hit[0] |=> event_flag_q[0];
  endproperty
  a_event: assert property (p_event) else $error("module flag not set");

  property p_aux_event;
    @(posedge clk) disable iff (!reset_n)
    module_hit[6] |=> aux6_q[pcatb_pkg::AUX_EVENT_FLAG];
  endproperty
  a_aux_event: assert property (p_aux_event) else $error("module 6 flag not set");

  property p_irq_mask;
    @(posedge clk) disable iff (!reset_n)
    (all_flags == 8'h00 && !mode_q[pcatb_pkg::MODE_OVF_IRQ_EN]) |=> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt raised");

  property p_pair;
    @(posedge clk) disable iff (!reset_n)
    !(module_mode_ok[0] && module_mode_ok[1]) |=> !pair_buffer_active[0];
  endproperty
  a_pair: assert property (p_pair) else $error("pair buffer active without modes");

endmodule : pcatb_timebase
`default_nettype wire

// >>> pcatb_pkg.sv
// Constants for the counter array time base: register map, fields, codes.
// Assumes a byte-wide special-function-register bus with a page select.
package pcatb_pkg;

  // ****************************************
  // Register addresses and pages
  // ****************************************
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCE;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCF;
  localparam logic [7:0] ADDR_CONTROL = 8'hD8;
  localparam logic [7:0] ADDR_MODE = 8'hD9;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hE9;
  localparam logic [7:0] ADDR_PWM_AUX6 = 8'hF2;
  localparam logic [7:0] ADDR_PWM_AUX7 = 8'hF3;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hF9;
  localparam logic [3:0] PAGE_MAIN = 4'h0;
  localparam logic [3:0] PAGE_AUX = 4'h1;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_OVERFLOW_FLAG = 7;
  localparam int CTRL_COUNTER_RUN = 6;
  localparam int MODE_IDLE_GATE = 7;
  localparam int MODE_PAIR45 = 6;
  localparam int MODE_PAIR23 = 5;
  localparam int MODE_PAIR01 = 4;
  localparam int MODE_SEL_HI = 3;
  localparam int MODE_SEL_LO = 1;
  localparam int MODE_OVF_IRQ_EN = 0;
  localparam int AUX_EVENT_FLAG = 3;
  localparam logic [7:0] AUX_WRITE_MASK = 8'hCF;

  // ****************************************
  // Reset values and counter limit
  // ****************************************
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_COUNT = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;

  // ****************************************
  // Tick source codes and dividers
  // ****************************************
  localparam logic [2:0] SRC_DIV12 = 3'h0;
  localparam logic [2:0] SRC_DIV2 = 3'h1;
  localparam logic [2:0] SRC_TIMER0 = 3'h2;
  localparam logic [2:0] SRC_EXT_PIN = 3'h3;
  localparam logic [2:0] SRC_FAST_MIX = 3'h4;
  localparam logic [2:0] SRC_DIV1 = 3'h5;
  localparam logic [2:0] SRC_UART0 = 3'h6;
  localparam logic [2:0] SRC_MASTER_DIV = 3'h7;
  localparam logic [3:0] DIV12_LAST = 4'hB;

endpackage : pcatb_pkg

// >>> pcatb_edge_sync.sv
// Two-stage synchroniser with rise and fall detection.
// Assumes the input is asynchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module pcatb_edge_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic async_in,
  output logic rise,
  output logic fall
);

  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;

endmodule : pcatb_edge_sync
`default_nettype wire

// >>> pcatb_prescale.sv
// Fixed dividers of the system clock into one-cycle tick pulses.
// Assumes the system tick equals clk.
`timescale 1ns/1ns
`default_nettype none
module pcatb_prescale (
  input wire logic clk,
  input wire logic reset_n,
  output logic tick_div12,
  output logic tick_div2
);

  logic [3:0] div12_q;
  logic div2_q;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div12_q <= 4'h0;
    end else if (div12_q == pcatb_pkg::DIV12_LAST) begin
      div12_q <= 4'h0;
    end else begin
      div12_q <= div12_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div2_q <= 1'b0;
    end else begin
      div2_q <= ~div2_q;
    end
  end

  assign tick_div12 = (div12_q == pcatb_pkg::DIV12_LAST);
  assign tick_div2 = div2_q;

endmodule : pcatb_prescale
`default_nettype wire

// >>> programmable_counter_array_timebase_tb_top.sv
// Self-checking bench for the counter array time base, driven over its register bus.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ns
`default_nettype none
module programmable_counter_array_timebase_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [3:0] sfr_page = 4'h0;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic cpu_idle = 1'b0;
  logic timer0_overflow = 1'b0;
  logic uart0_rate_gen_overflow = 1'b0;
  logic ext_tick_pin = 1'b1;
  logic fast_mix_source = 1'b0;
  logic master_divider_out = 1'b0;
  logic toggle_pin_enable = 1'b0;
  logic overflow_toggle_out;
  logic toggle_pin_o;
  logic toggle_pin_oe;
  logic [7:0] module_hit = 8'h00;
  logic [7:0] module_irq_enable = 8'h00;
  logic [5:0] module_mode_ok = 6'h00;
  logic [2:0] pair_buffer_active;
  logic [15:0] count_value;
  logic count_tick;
  logic [7:0] module_pin_use = 8'h0F;
  logic [7:0] module_pin_drive = 8'h05;
  logic [7:0] module_pin_drive_oe = 8'h0F;
  logic [7:0] gpio_out = 8'hA0;
  logic [7:0] gpio_oe = 8'hF0;
  logic [7:0] module_pin_o;
  logic [7:0] module_pin_oe;
  logic irq;
  int err_total = 0;
  int compares = 0;
  int src_exp[8] = '{4, 24, 4, 4, 4, 48, 4, 4};
  logic tog;
  logic [15:0] held;

  pcatb_timebase i_dut (.clk(clk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_page(sfr_page),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cpu_idle(cpu_idle), .timer0_overflow(timer0_overflow),
    .uart0_rate_gen_overflow(uart0_rate_gen_overflow), .ext_tick_pin(ext_tick_pin),
    .fast_mix_source(fast_mix_source), .master_divider_out(master_divider_out),
    .toggle_pin_enable(toggle_pin_enable), .overflow_toggle_out(overflow_toggle_out),
    .toggle_pin_o(toggle_pin_o), .toggle_pin_oe(toggle_pin_oe), .module_hit(module_hit),
    .module_irq_enable(module_irq_enable), .module_mode_ok(module_mode_ok),
    .pair_buffer_active(pair_buffer_active), .count_value(count_value), .count_tick(count_tick),
    .module_pin_use(module_pin_use), .module_pin_drive(module_pin_drive),
    .module_pin_drive_oe(module_pin_drive_oe), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .module_pin_o(module_pin_o), .module_pin_oe(module_pin_oe), .irq(irq));

  initial begin
    forever #2 clk = ~clk;
  end

  // ****************************************
  // Bus tasks and checks
  // ****************************************
  task automatic final_report();
    if (err_total == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] e);
    @(negedge clk);
    sfr_addr = a;
    sfr_page = p;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    chk({8'h00, sfr_rdata}, {8'h00, e});
  endtask : rd

  // Counts ticks over 48 cycles while each bench-driven source sees four events.
  task automatic window(input logic [7:0] mode, input int exp_n);
    int n;
    n = 0;
    wr(8'hD9, 4'h0, mode);
    for (int i = 0; i <= 48; i++) begin
      @(negedge clk);
      if (i > 0 && count_tick === 1'b1) begin
        n++;
      end
      timer0_overflow = (i % 8 == 0) && (i < 32);
      uart0_rate_gen_overflow = (i % 8 == 0) && (i < 32);
      fast_mix_source = (i % 8 < 2) && (i < 32);
      master_divider_out = (i % 8 < 2) && (i < 32);
      ext_tick_pin = !((i % 8 < 2) && (i < 32));
    end
    chk(16'(n), 16'(exp_n));
  endtask : window

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (3) @(negedge clk);
    reset_n = 1'b1;
    rd(8'hCE, 4'h0, 8'h00);
    rd(8'hCF, 4'h0, 8'h00);
    rd(8'hD8, 4'h0, 8'h00);
    rd(8'hD9, 4'h0, 8'h00);
    rd(8'hE9, 4'h0, 8'h00);
    rd(8'hF9, 4'h0, 8'h00);
    rd(8'hF3, 4'h1, 8'h00);
    wr(8'hCE, 4'h3, 8'h5A);
    rd(8'hCE, 4'h0, 8'h5A);
    wr(8'hF2, 4'h1, 8'hFF);
    rd(8'hF2, 4'h1, pcatb_pkg::AUX_WRITE_MASK);
    wr(8'hF2, 4'h1, 8'h00);
    wr(8'hD8, 4'h0, 8'h40);
    rd(8'hD8, 4'h1, 8'h00);
    rd(8'hA0, 4'h0, 8'h00);
    for (int c = 0; c < 8; c++) begin
      window({4'h0, 3'(c), 1'b0}, src_exp[c]);
    end
    cpu_idle = 1'b1;
    window(8'h8A, 0);
    window(8'h0A, 48);
    cpu_idle = 1'b0;
    window(8'h8A, 48);
    wr(8'hD8, 4'h0, 8'h00);
    wr(8'hCF, 4'h0, 8'hAB);
    wr(8'hCE, 4'h0, 8'hCD);
    wr(8'hF9, 4'h0, 8'hFF);
    wr(8'hE9, 4'h0, 8'hFD);
    toggle_pin_enable = 1'b1;
    tog = overflow_toggle_out;
    wr(8'hD8, 4'h0, 8'h40);
    for (int k = 0; overflow_toggle_out === tog; k++) begin
      if (k > 20) begin
        err_total++;
        final_report();
      end
      @(negedge clk);
    end
    chk(count_value, 16'hABCD);
    chk({15'h0, toggle_pin_o}, {15'h0, ~tog});
    chk({15'h0, toggle_pin_oe}, 16'h0001);
    rd(8'hD8, 4'h0, 8'hC0);
    wr(8'hD8, 4'h0, 8'h80);
    rd(8'hD8, 4'h0, 8'h80);
    chk({15'h0, irq}, 16'h0000);
    held = count_value;
    repeat (20) @(negedge clk);
    chk(count_value, held);
    wr(8'hD9, 4'h0, 8'h0B);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(8'hD8, 4'h0, 8'h00);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0000);
    wr(8'hD8, 4'h0, 8'h80);
    @(negedge clk);
    chk({15'h0, irq}, 16'h0001);
    wr(8'hD8, 4'h0, 8'h00);
    wr(8'hD9, 4'h0, 8'h00);
    toggle_pin_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk({15'h0, toggle_pin_oe}, 16'h0000);
    module_irq_enable = 8'h84;
    for (int m = 0; m < 8; m++) begin
      @(negedge clk);
      module_hit = 8'h01 << m;
      @(negedge clk);
      module_hit = 8'h00;
      if (m < 6) begin
        rd(8'hD8, 4'h0, 8'h01 << m);
        chk({15'h0, irq}, {15'h0, m == 2});
        wr(8'hD8, 4'h0, 8'h00);
      end else begin
        rd(8'hF0 + 8'(m - 4), 4'h1, 8'h08);
        chk({15'h0, irq}, {15'h0, m == 7});
        wr(8'hF0 + 8'(m - 4), 4'h1, 8'h00);
      end
    end
    module_mode_ok = 6'b000011;
    wr(8'hD9, 4'h0, 8'h70);
    repeat (2) @(negedge clk);
    chk({13'h0, pair_buffer_active}, 16'h0001);
    module_mode_ok = 6'h3F;
    repeat (2) @(negedge clk);
    chk({13'h0, pair_buffer_active}, 16'h0007);
    chk({8'h00, module_pin_o}, 16'h00A5);
    chk({8'h00, module_pin_oe}, 16'h00FF);
    final_report();
  end
endmodule : programmable_counter_array_timebase_tb_top
`default_nettype wire
